// [src/rx_slot_cond.sv]
// receive timeslot conditioning, signaling substitution, debounce and overhead routing
`timescale 1ns/100ps
module rx_slot_cond
  import rx_cond_pkg::*;
(
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  // register port
  input  wire logic [15:0] i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [7:0]  o_reg_rdata,
  // received stream
  input  wire pcm_octet_s  i_rx_octet,
  input  wire logic [31:0] i_de_octets,
  input  wire sig_word_s   i_rx_sig,
  // backplane side
  output pcm_octet_s       o_rx_pcm_serial_out,
  output sig_word_s        o_rx_signaling_pin,
  output sig_word_s        o_rx_overhead_pin
);

  logic [3:0]  rx_slot_condition_code [24];
  logic [7:0]  rx_user_code_value     [24];
  logic [7:0]  rx_signaling_control   [24];
  logic [3:0]  rx_signaling_substitute_values [24];
  logic [3:0]  rx_signaling_array     [24];
  logic [3:0]  sig_pending            [24];
  logic [2:0]  de_select_reg;
  logic        ptype_reg;
  logic [7:0]  rdata_reg;
  logic [2:0]  mw_phase_reg;
  logic [14:0] prbs_reg;
  logic [19:0] qrts_reg;
  pcm_octet_s  pcm_reg;
  sig_word_s   sig_pin_reg;
  sig_word_s   oh_pin_reg;

  // register decode
  wire [4:0]  wr_idx     = i_reg_addr[4:0];
  wire        idx_ok     = wr_idx <= LAST_SLOT;
  wire        hit_cond   = idx_ok && (i_reg_addr[15:5] == COND_BASE[15:5]);
  wire        hit_user   = idx_ok && (i_reg_addr[15:5] == USER_BASE[15:5]);
  wire        hit_sigctl = idx_ok && (i_reg_addr[15:5] == SIGCTL_BASE[15:5]);
  wire        hit_sigsub = idx_ok && (i_reg_addr[15:5] == SIGSUB_BASE[15:5]);
  wire        hit_sigarr = idx_ok && (i_reg_addr[15:5] == SIGARR_BASE[15:5]);
  wire        hit_de     = i_reg_addr == DE_SEL_ADDR;
  wire        hit_ptype  = i_reg_addr == PTYPE_ADDR;
  wire [7:0]  rdata_next =
    !i_reg_rd  ? 8'h00 :
    hit_cond   ? {4'h0, rx_slot_condition_code[wr_idx]} :
    hit_user   ? rx_user_code_value[wr_idx] :
    hit_sigctl ? rx_signaling_control[wr_idx] :
    hit_sigsub ? {4'h0, rx_signaling_substitute_values[wr_idx]} :
    hit_sigarr ? {4'h0, rx_signaling_array[wr_idx]} :
    hit_de     ? {5'h00, de_select_reg} :
    hit_ptype  ? {ptype_reg, 7'h00} :
    8'h00;

  // octet path selection
  wire        in_ok     = i_rx_octet.valid && (i_rx_octet.slot <= LAST_SLOT);
  wire [4:0]  in_slot   = in_ok ? i_rx_octet.slot : 5'h00;
  wire [7:0]  rx_data   = i_rx_octet.data;
  wire [3:0]  cur_code  = rx_slot_condition_code[in_slot];
  wire [7:0]  cur_user  = rx_user_code_value[in_slot];
  wire [7:0]  cur_ctl   = rx_signaling_control[in_slot];
  wire [3:0]  cur_sub   = rx_signaling_substitute_values[in_slot];
  wire [5:0]  mw_shift  = {~mw_phase_reg, 3'h0};
  wire [7:0]  mw_alaw   = MW_ALAW[mw_shift +: 8];
  wire [7:0]  mw_mulaw  = MW_MULAW[mw_shift +: 8];
  wire [4:0]  de_shift  = {de_select_reg[1:0], 3'h0};
  wire [7:0]  de_octet  = i_de_octets[de_shift +: 8];
  wire        frame_end = in_ok && (i_rx_octet.slot == LAST_SLOT);
  wire        prbs_use  = in_ok && (cur_code == COND_PRBS);
  wire        sub_here  = cur_ctl[SIGC_BIT] && (i_rx_octet.sig_bit != 3'h0) && (i_rx_octet.sig_bit <= 3'h4);
  wire [1:0]  sub_pos   = 2'(3'h4 - i_rx_octet.sig_bit);

  logic [7:0]  cond_octet;
  logic [7:0]  prbs_bits;
  logic [7:0]  qrts_bits;
  logic [14:0] prbs_next;
  logic [19:0] qrts_next;

  always_comb
  begin
    case (cur_code)
      COND_INV_ALL:  cond_octet = rx_data ^ XOR_ALL;
      COND_INV_EVEN: cond_octet = rx_data ^ XOR_EVEN;
      COND_INV_ODD:  cond_octet = rx_data ^ XOR_ODD;
      COND_USER:     cond_octet = cur_user;
      COND_BUSY:     cond_octet = BUSY_OCTET;
      COND_VACANT:   cond_octet = VACANT_OCTET;
      COND_BUSY_TS:  cond_octet = {BUSY_TS_PREFIX, in_slot};
      COND_MOOF:     cond_octet = MOOF_OCTET;
      COND_MW_ALAW:  cond_octet = mw_alaw;
      COND_MW_MULAW: cond_octet = mw_mulaw;
      COND_INV_MSB:  cond_octet = rx_data ^ MSB_MASK;
      COND_INV_LOW:  cond_octet = rx_data ^ LOW_MASK;
      COND_PRBS:     cond_octet = ptype_reg ? qrts_bits : prbs_bits;
      COND_DE:       cond_octet = de_octet;
      default:       cond_octet = rx_data;
    endcase
  end

  // only the generator picked by ptype_reg steps eight bits per substituted octet; the quasi-random
  // source is a plain 20-stage sequence, without the 14-zero suppression
  always_comb
  begin
    prbs_next = prbs_reg;
    qrts_next = qrts_reg;
    prbs_bits = 8'h00;
    qrts_bits = 8'h00;
    for (int k = 0; k < 8; k++)
    begin
      prbs_bits = {prbs_bits[6:0], prbs_next[14] ^ prbs_next[13]};
      prbs_next = {prbs_next[13:0], prbs_next[14] ^ prbs_next[13]};
      qrts_bits = {qrts_bits[6:0], qrts_next[19] ^ qrts_next[16]};
      qrts_next = {qrts_next[18:0], qrts_next[19] ^ qrts_next[16]};
    end
  end

  // substitution acts on the PCM copy only
  wire [7:0]  pcm_data  = sub_here ? {cond_octet[7:1], cur_sub[sub_pos]} : cond_octet;

  // signaling path
  wire        sig_ok    = i_rx_sig.valid && (i_rx_sig.slot <= LAST_SLOT);
  wire [4:0]  sig_slot  = sig_ok ? i_rx_sig.slot : 5'h00;
  wire [7:0]  sig_ctl   = rx_signaling_control[sig_slot];
  wire        sig_same  = i_rx_sig.abcd == sig_pending[sig_slot];
  wire        sig_take  = sig_ok && (!sig_ctl[DEB_BIT] || sig_same);
  wire [3:0]  arr_next  = sig_take ? i_rx_sig.abcd : rx_signaling_array[sig_slot];

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      for (int s = 0; s < 24; s++)
      begin
        rx_slot_condition_code[s]         <= COND_RST;
        rx_user_code_value[s]             <= USER_RST;
        rx_signaling_control[s]           <= SIGCTL_RST;
        rx_signaling_substitute_values[s] <= SIGSUB_RST;
      end
      de_select_reg <= 3'h0;
      ptype_reg     <= 1'b0;
      rdata_reg     <= 8'h00;
    end
    else
    begin
      if (i_reg_wr && hit_cond)
        rx_slot_condition_code[wr_idx] <= i_reg_wdata[3:0];
      if (i_reg_wr && hit_user)
        rx_user_code_value[wr_idx] <= i_reg_wdata;
      if (i_reg_wr && hit_sigctl)
        rx_signaling_control[wr_idx] <= i_reg_wdata;
      if (i_reg_wr && hit_sigsub)
        rx_signaling_substitute_values[wr_idx] <= i_reg_wdata[3:0];
      if (i_reg_wr && hit_de)
        de_select_reg <= i_reg_wdata[2:0];
      if (i_reg_wr && hit_ptype)
        ptype_reg <= i_reg_wdata[PTYPE_BIT];
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      mw_phase_reg <= 3'h0;
      prbs_reg     <= PRBS_SEED;
      qrts_reg     <= QRTS_SEED;
      pcm_reg      <= '0;
    end
    else
    begin
      if (frame_end)
        mw_phase_reg <= mw_phase_reg + 3'h1;
      if (prbs_use && !ptype_reg)
        prbs_reg <= prbs_next;
      if (prbs_use && ptype_reg)
        qrts_reg <= qrts_next;
      pcm_reg <= '{valid: in_ok, slot: in_slot, sig_bit: i_rx_octet.sig_bit, data: pcm_data};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      for (int s = 0; s < 24; s++)
      begin
        rx_signaling_array[s] <= SIGARR_RST;
        sig_pending[s]        <= SIGARR_RST;
      end
      sig_pin_reg <= '0;
      oh_pin_reg  <= '0;
    end
    else
    begin
      if (sig_ok)
        sig_pending[sig_slot] <= i_rx_sig.abcd;
      if (sig_take)
        rx_signaling_array[sig_slot] <= i_rx_sig.abcd;
      sig_pin_reg <= '{valid: sig_ok, slot: sig_slot, abcd: arr_next};
      oh_pin_reg  <= '{valid: sig_ok && sig_ctl[OH_BIT], slot: sig_slot, abcd: arr_next};
    end
  end

  assign o_reg_rdata         = rdata_reg;
  assign o_rx_pcm_serial_out = pcm_reg;
  assign o_rx_signaling_pin  = sig_pin_reg;
  assign o_rx_overhead_pin   = oh_pin_reg;

  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  wire plain = in_ok && !sub_here;

  AST_BUSY: assert property (plain && cur_code == COND_BUSY |=> o_rx_pcm_serial_out.data == 8'h7f)
    else $error("busy octet not sent");
  AST_VACANT: assert property (plain && cur_code == COND_VACANT |=> o_rx_pcm_serial_out.data == 8'hff)
    else $error("vacant octet not sent");
  AST_BUSY_TS: assert property (plain && cur_code == COND_BUSY_TS
    |=> o_rx_pcm_serial_out.data == {3'h7, $past(i_rx_octet.slot)})
    else $error("numbered busy octet wrong");
  AST_MOOF: assert property (plain && cur_code == COND_MOOF |=> o_rx_pcm_serial_out.data == 8'h1a)
    else $error("out-of-frame octet not sent");
  AST_MW_SEQ: assert property (plain && cur_code == COND_MW_MULAW && mw_phase_reg == 3'h0
    |=> o_rx_pcm_serial_out.data == 8'h1e)
    else $error("milliwatt sequence start wrong");
  AST_MW_ADV: assert property (frame_end |=> mw_phase_reg == 3'($past(mw_phase_reg) + 3'h1))
    else $error("milliwatt phase did not advance");
  AST_INV_MSB: assert property (plain && cur_code == COND_INV_MSB
    |=> o_rx_pcm_serial_out.data == ($past(i_rx_octet.data) ^ 8'h80))
    else $error("msb inversion wrong");
  AST_INV_LOW: assert property (plain && cur_code == COND_INV_LOW
    |=> o_rx_pcm_serial_out.data == ($past(i_rx_octet.data) ^ 8'h7f))
    else $error("low bit inversion wrong");
  AST_USER: assert property (plain && cur_code == COND_USER |=> o_rx_pcm_serial_out.data == $past(cur_user))
    else $error("user octet not sent");
  AST_PASS: assert property (plain && (cur_code == COND_PASS || cur_code == COND_PASS_E)
    |=> o_rx_pcm_serial_out.data == $past(i_rx_octet.data) && o_rx_pcm_serial_out.valid)
    else $error("pass-through octet altered");
  AST_XOR_EVEN: assert property (plain && cur_code == COND_INV_EVEN
    |=> o_rx_pcm_serial_out.data == ($past(i_rx_octet.data) ^ 8'haa))
    else $error("even inversion wrong");
  AST_SUBST: assert property (in_ok && sub_here && cur_code == COND_PASS && i_rx_octet.sig_bit == 3'h1
    |=> o_rx_pcm_serial_out.data[0] == $past(cur_sub[3]))
    else $error("signaling bit A not substituted");
  AST_PIN_RAW: assert property (sig_ok |=> o_rx_signaling_pin.abcd == rx_signaling_array[o_rx_signaling_pin.slot])
    else $error("signaling pin differs from array");
  AST_OH: assert property (sig_ok |=> o_rx_overhead_pin.valid == $past(sig_ctl[OH_BIT]))
    else $error("overhead output enable ignored");
  AST_DEB_HOLD: assert property (sig_ok && sig_ctl[DEB_BIT] && !sig_same
    |=> o_rx_signaling_pin.abcd == $past(rx_signaling_array[sig_slot]))
    else $error("debounced signaling changed early");
  AST_DEB_TAKE: assert property (sig_ok && sig_ctl[DEB_BIT] && sig_same
    |=> o_rx_signaling_pin.abcd == $past(i_rx_sig.abcd))
    else $error("debounced signaling not taken");
  AST_NODEB: assert property (sig_ok && !sig_ctl[DEB_BIT] |=> o_rx_signaling_pin.abcd == $past(i_rx_sig.abcd))
    else $error("signaling not updated at once");
  AST_XOR_ALL: assert property (plain && cur_code == COND_INV_ALL
    |=> o_rx_pcm_serial_out.data == ($past(i_rx_octet.data) ^ 8'hff))
    else $error("full inversion wrong");
  AST_XOR_ODD: assert property (plain && cur_code == COND_INV_ODD
    |=> o_rx_pcm_serial_out.data == ($past(i_rx_octet.data) ^ 8'h55))
    else $error("odd inversion wrong");
  AST_MW_ALAW: assert property (plain && cur_code == COND_MW_ALAW && mw_phase_reg == 3'h0
    |=> o_rx_pcm_serial_out.data == 8'h34)
    else $error("a-law milliwatt start wrong");
  AST_DE: assert property (plain && cur_code == COND_DE && de_select_reg[1:0] == 2'h0
    |=> o_rx_pcm_serial_out.data == $past(i_de_octets[7:0]))
    else $error("data link octet not taken");
  AST_SLOT_OUT: assert property (in_ok
    |=> o_rx_pcm_serial_out.valid && o_rx_pcm_serial_out.slot == $past(i_rx_octet.slot))
    else $error("octet slot not carried");
  AST_OH_DATA: assert property (sig_ok && sig_ctl[OH_BIT]
    |=> o_rx_overhead_pin.abcd == o_rx_signaling_pin.abcd)
    else $error("overhead pin differs from array");

  COV_PRBS: cover property (prbs_use ##2 prbs_use);
  COV_SUBST: cover property (in_ok && sub_here);
  COV_DEB_HOLD: cover property (sig_ok && sig_ctl[DEB_BIT] && !sig_same);
  COV_MW_WRAP: cover property (frame_end && mw_phase_reg == 3'h7);

endmodule

// [src/rx_cond_pkg.sv]
// constants, codes and carriers for the receive timeslot conditioning and signaling block
// Summary of operation
// - code 0x5 replaces the timeslot octet with the busy octet 0x7f.
// - code 0x6 replaces the timeslot octet with the vacant octet 0xff.
// - code 0x7 sends 111 followed by the timeslot number.
// - code 0x8 replaces the octet with the out-of-frame code 0x1a.
// - codes 0x9 and 0xa send the A-law and mu-law milliwatt sequences.
// - code 0xb inverts only the most significant bit of the octet.
// - code 0xc inverts every bit except the most significant one.
// - code 0xd sends pseudo-random data, type chosen by pattern type bit.
// - code 0xf takes the octet from the selected D/E data source.
// - each slot has a user octet, reset all ones, sent under code 0x4.
// - substitution enable bit 6 replaces received ABCD bits with programmed values.
// - substitution touches PCM output only; array and signaling pin keep received bits.
// - overhead enable bit 5 drives the slot's array contents onto the overhead pin.
// - with debounce bit 4, update array and pin after two equal superframes.
// - with debounce, differing consecutive superframes leave array and pin unchanged.
// - without debounce, array and pin follow every received signaling change.
// - every slot has a 4-bit code; codes 0x0 and 0xe pass the octet.
// - codes 0x1, 0x2, 0x3 xor the octet with 0xff, 0xaa, 0x55.
// - conditioning is applied per slot before the octet reaches the backplane.
package rx_cond_pkg;

  localparam logic [4:0]  LAST_SLOT      = 5'h17;
  localparam logic [15:0] COND_BASE      = 16'h0360;
  localparam logic [15:0] USER_BASE      = 16'h0380;
  localparam logic [15:0] SIGCTL_BASE    = 16'h03a0;
  localparam logic [15:0] SIGSUB_BASE    = 16'h0400;
  localparam logic [15:0] SIGARR_BASE    = 16'h0500;
  localparam logic [15:0] DE_SEL_ADDR    = 16'h010c;
  localparam logic [15:0] PTYPE_ADDR     = 16'h0123;
  localparam int          SIGC_BIT       = 6;
  localparam int          OH_BIT         = 5;
  localparam int          DEB_BIT        = 4;
  localparam int          PTYPE_BIT      = 7;
  localparam logic [3:0]  COND_RST       = 4'h0;
  localparam logic [7:0]  USER_RST       = 8'hff;
  localparam logic [7:0]  SIGCTL_RST     = 8'h00;
  localparam logic [3:0]  SIGSUB_RST     = 4'h0;
  localparam logic [3:0]  SIGARR_RST     = 4'h0;
  localparam logic [7:0]  BUSY_OCTET     = 8'h7f;
  localparam logic [7:0]  VACANT_OCTET   = 8'hff;
  localparam logic [7:0]  MOOF_OCTET     = 8'h1a;
  localparam logic [7:0]  XOR_ALL        = 8'hff;
  localparam logic [7:0]  XOR_EVEN       = 8'haa;
  localparam logic [7:0]  XOR_ODD        = 8'h55;
  localparam logic [7:0]  MSB_MASK       = 8'h80;
  localparam logic [7:0]  LOW_MASK       = 8'h7f;
  localparam logic [2:0]  BUSY_TS_PREFIX = 3'h7;
  localparam logic [63:0] MW_ALAW        = 64'h3421_2134_b4a1_a1b4;
  localparam logic [63:0] MW_MULAW       = 64'h1e0b_0b1e_9e8b_8b9e;
  localparam logic [14:0] PRBS_SEED      = 15'h7fff;
  localparam logic [19:0] QRTS_SEED      = 20'hfffff;

  typedef enum logic [3:0] {
    COND_PASS     = 4'h0,
    COND_INV_ALL  = 4'h1,
    COND_INV_EVEN = 4'h2,
    COND_INV_ODD  = 4'h3,
    COND_USER     = 4'h4,
    COND_BUSY     = 4'h5,
    COND_VACANT   = 4'h6,
    COND_BUSY_TS  = 4'h7,
    COND_MOOF     = 4'h8,
    COND_MW_ALAW  = 4'h9,
    COND_MW_MULAW = 4'ha,
    COND_INV_MSB  = 4'hb,
    COND_INV_LOW  = 4'hc,
    COND_PRBS     = 4'hd,
    COND_PASS_E   = 4'he,
    COND_DE       = 4'hf
  } cond_code_e;

  // sig_bit: 0 = plain octet, 1..4 = LSB carries robbed bit A..D
  typedef struct packed {
    logic       valid;
    logic [4:0] slot;
    logic [2:0] sig_bit;
    logic [7:0] data;
  } pcm_octet_s;

  // abcd[3] is bit A, abcd[0] is bit D
  typedef struct packed {
    logic       valid;
    logic [4:0] slot;
    logic [3:0] abcd;
  } sig_word_s;

endpackage

// [testbench/rx_backplane_sink.sv]
// backplane-side sink that tallies conditioned octets and signaling reports
`timescale 1ns/100ps
module rx_backplane_sink
  import rx_cond_pkg::*;
(
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_resetn,
  // block outputs seen by the backplane
  input  wire pcm_octet_s i_pcm,
  input  wire sig_word_s  i_sig,
  input  wire sig_word_s  i_oh,
  // tallies
  output logic [15:0]     o_octet_count,
  output logic [15:0]     o_report_count,
  output logic [15:0]     o_oh_count
);
  // a pure listener: the backplane never pushes back on this block
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_octet_count  <= 16'h0000;
      o_report_count <= 16'h0000;
      o_oh_count     <= 16'h0000;
    end
    else
    begin
      o_octet_count  <= o_octet_count + {15'h0, i_pcm.valid};
      o_report_count <= o_report_count + {15'h0, i_sig.valid};
      o_oh_count     <= o_oh_count + {15'h0, i_oh.valid};
    end
  end
endmodule

// [testbench/test_rx_slot_cond.sv]
// self-checking bench for the receive timeslot conditioning block
`timescale 1ns/100ps
module test_rx_slot_cond;
  import rx_cond_pkg::*;
  logic        i_sys_clk   = 1'b0;
  logic        i_resetn    = 1'b0;
  logic [15:0] i_reg_addr  = 16'h0000;
  logic [7:0]  i_reg_wdata = 8'h00;
  logic        i_reg_wr    = 1'b0;
  logic        i_reg_rd    = 1'b0;
  logic [7:0]  o_reg_rdata;
  pcm_octet_s  i_rx_octet  = '0;
  logic [31:0] i_de_octets = 32'h4433_2211;
  sig_word_s   i_rx_sig    = '0;
  pcm_octet_s  o_rx_pcm_serial_out;
  sig_word_s   o_rx_signaling_pin;
  sig_word_s   o_rx_overhead_pin;
  logic [15:0] n_oct, n_rep, n_oh;
  int          n_errors    = 0;
  int          cmp_count   = 0;
  int          cycles      = 0;
  int          sent_oct    = 0;
  int          sent_oh     = 0;
  int          sent_sig    = 0;

  rx_slot_cond DUT (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .i_rx_octet(i_rx_octet), .i_de_octets(i_de_octets), .i_rx_sig(i_rx_sig),
    .o_rx_pcm_serial_out(o_rx_pcm_serial_out), .o_rx_signaling_pin(o_rx_signaling_pin),
    .o_rx_overhead_pin(o_rx_overhead_pin));

  rx_backplane_sink sink (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_pcm(o_rx_pcm_serial_out),
    .i_sig(o_rx_signaling_pin), .i_oh(o_rx_overhead_pin), .o_octet_count(n_oct),
    .o_report_count(n_rep), .o_oh_count(n_oh));

  always #20 i_sys_clk = ~i_sys_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // a hung handshake cannot stall the run past this ceiling
  always @(posedge i_sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_wr    <= 1'b0;
  endtask

  // read data are valid only in the single cycle after the strobe
  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_rd   <= 1'b0;
    #1 check({24'h0, o_reg_rdata}, {24'h0, exp});
  endtask

  task automatic octc(input logic [4:0] s, input logic [2:0] b, input logic [7:0] d, input logic [7:0] exp);
    @(posedge i_sys_clk);
    i_rx_octet <= {1'b1, s, b, d};
    @(posedge i_sys_clk);
    i_rx_octet <= '0;
    sent_oct++;
    #1 check({15'h0, o_rx_pcm_serial_out}, {15'h0, 1'b1, s, b, exp});
  endtask

  task automatic sigc(input logic [4:0] s, input logic [3:0] abcd, input logic [3:0] exp, input logic oh);
    @(posedge i_sys_clk);
    i_rx_sig <= {1'b1, s, abcd};
    @(posedge i_sys_clk);
    i_rx_sig <= '0;
    sent_sig++;
    if (oh)
      sent_oh++;
    #1 check({22'h0, o_rx_signaling_pin}, {22'h0, 1'b1, s, exp});
    check({31'h0, o_rx_overhead_pin.valid}, {31'h0, oh});
    if (oh)
      check({28'h0, o_rx_overhead_pin.abcd}, {28'h0, exp});
  endtask

  task automatic test_reset_regs;
    rdc(16'h0380, 8'hff);
    rdc(16'h0397, 8'hff);
    rdc(16'h0360, 8'h00);
    rdc(16'h03a0, 8'h00);
    wr(16'h0398, 8'h5a);
    rdc(16'h0398, 8'h00);
    wr(16'h0385, 8'hc3);
    rdc(16'h0385, 8'hc3);
    $display("reset and register map done");
  endtask

  task automatic test_codes;
    logic [7:0] e;
    for (int c = 0; c < 16; c++)
    begin
      if (c == 9 || c == 10 || c == 13 || c == 15)
        continue;
      case (c)
        1: e = 8'h3c ^ 8'hff;
        2: e = 8'h3c ^ 8'haa;
        3: e = 8'h3c ^ 8'h55;
        4: e = 8'hc3;
        5: e = 8'h7f;
        6: e = 8'hff;
        7: e = 8'he5;
        8: e = 8'h1a;
        11: e = 8'hbc;
        12: e = 8'h43;
        default: e = 8'h3c;
      endcase
      wr(16'h0365, c[7:0]);
      octc(5'd5, 3'd0, 8'h3c, e);
    end
    $display("conditioning codes done");
  endtask

  task automatic test_milliwatt;
    wr(16'h0362, 8'h09);
    wr(16'h0364, 8'h0a);
    wr(16'h0377, 8'h07);
    octc(5'd2, 3'd0, 8'h00, 8'h34);
    octc(5'd4, 3'd0, 8'h00, 8'h1e);
    octc(5'd23, 3'd0, 8'h00, 8'hf7);
    octc(5'd2, 3'd0, 8'h00, 8'h21);
    octc(5'd4, 3'd0, 8'h00, 8'h0b);
    $display("milliwatt done");
  endtask

  task automatic test_de_prbs;
    wr(16'h0366, 8'h0f);
    octc(5'd6, 3'd0, 8'h99, 8'h11);
    wr(16'h010c, 8'h02);
    rdc(16'h010c, 8'h02);
    octc(5'd6, 3'd0, 8'h99, 8'h33);
    wr(16'h0123, 8'h80);
    rdc(16'h0123, 8'h80);
    // from all-ones seeds both generators open with zero octets; the later octets show the taps
    wr(16'h0367, 8'h0d);
    octc(5'd7, 3'd0, 8'h99, 8'h00);
    octc(5'd7, 3'd0, 8'h99, 8'h00);
    octc(5'd7, 3'd0, 8'h99, 8'h70);
    wr(16'h0123, 8'h00);
    octc(5'd7, 3'd0, 8'h99, 8'h00);
    octc(5'd7, 3'd0, 8'h99, 8'h02);
    $display("data link and pattern select done");
  endtask

  task automatic test_sig_subst;
    wr(16'h0403, 8'h0a);
    wr(16'h03a3, 8'h40);
    octc(5'd3, 3'd1, 8'h00, 8'h01);
    octc(5'd3, 3'd2, 8'h01, 8'h00);
    octc(5'd3, 3'd0, 8'h01, 8'h01);
    sigc(5'd3, 4'h5, 4'h5, 1'b0);
    rdc(16'h0503, 8'h05);
    wr(16'h0503, 8'h0f);
    rdc(16'h0503, 8'h05);
    wr(16'h03a3, 8'h00);
    octc(5'd3, 3'd1, 8'h00, 8'h00);
    sigc(5'd3, 4'h6, 4'h6, 1'b0);
    $display("signaling substitution done");
  endtask

  task automatic test_overhead_debounce;
    wr(16'h03a8, 8'h20);
    sigc(5'd8, 4'h9, 4'h9, 1'b1);
    wr(16'h03a8, 8'h00);
    sigc(5'd8, 4'h2, 4'h2, 1'b0);
    wr(16'h03a9, 8'h10);
    sigc(5'd9, 4'h5, 4'h0, 1'b0);
    sigc(5'd9, 4'h5, 4'h5, 1'b0);
    sigc(5'd9, 4'h3, 4'h5, 1'b0);
    sigc(5'd9, 4'h6, 4'h5, 1'b0);
    rdc(16'h0509, 8'h05);
    $display("overhead and debounce done");
  endtask

  initial
  begin
    repeat (8) @(posedge i_sys_clk);
    check({24'h0, o_reg_rdata}, 32'h0);
    i_resetn <= 1'b1;
    test_reset_regs();
    test_codes();
    test_milliwatt();
    test_de_prbs();
    test_sig_subst();
    test_overhead_debounce();
    @(posedge i_sys_clk);
    #1 check({16'h0, n_oct}, sent_oct);
    check({16'h0, n_oh}, sent_oh);
    check({16'h0, n_rep}, sent_sig);
    give_verdict();
  end
endmodule
